//--- src/vic_pkg.sv
// Constants shared by the vectored interrupt controller files.
package vic_pkg;
	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int NUM_SRC = 118;
	localparam int NUM_TRAP = 8;
	localparam int NUM_VEC = 126;
	localparam int SLOTS = 128;
	localparam int SRC_PAD = 10;
	localparam int ALT_BIT = 15;
	localparam int SRC_EXTERNAL_REQUEST_ZERO = 0;

	// ****************************************************************
	// Register word addresses
	// ****************************************************************
	localparam logic [9:0] PEND_BASE = 10'h000;
	localparam logic [9:0] EN_BASE = 10'h010;
	localparam logic [9:0] PRIO_BASE = 10'h020;
	localparam logic [9:0] PRIO_END = 10'h03e;
	localparam logic [9:0] TRAP_ADDR = 10'h040;
	localparam logic [9:0] CTRL2_ADDR = 10'h041;
	localparam logic [9:0] STAT_ADDR = 10'h042;
	localparam logic [9:0] VMEM_BASE = 10'h200;

	// ****************************************************************
	// Field masks and reset values
	// ****************************************************************
	localparam logic [15:0] PRIO_MASK = 16'h7777;
	localparam logic [15:0] TRAP_MASK = 16'h001e;
	localparam logic [15:0] CTRL2_MASK = 16'h8000;
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [127:0] SRC_VALID = {{SRC_PAD{1'b0}}, {NUM_SRC{1'b1}}};
	localparam logic [2:0] LEVEL_ALL_BLOCKED = 3'h7;

	// ****************************************************************
	// Program memory addresses
	// ****************************************************************
	localparam logic [23:0] RESET_ADDR = 24'h000000;
	localparam logic [23:0] PRI_TABLE_BASE = 24'h000004;
	localparam logic [23:0] ALT_TABLE_BASE = 24'h000104;
	localparam logic [23:0] SRC_TABLE_BASE = 24'h000014;

	// ****************************************************************
	// Trap vector numbers
	// ****************************************************************
	localparam int TRAP_OSC_FAIL = 1;
	localparam int TRAP_ADDR_ERR = 2;
	localparam int TRAP_STACK_ERR = 3;
	localparam int TRAP_MATH_ERR = 4;

	// Cycles from a winning candidate to the request output.
	localparam int DISPATCH_LATENCY = 2;
endpackage

//--- src/vic_arbiter.sv
// Priority arbiter: traps first, then user level, then natural vector order.
`timescale 1ns/10ps
module vic_arbiter (
	input wire logic [127:0] i_pend,
	input wire logic [127:0] i_en,
	input wire logic [511:0] i_prio,
	input wire logic [7:0] i_trap,
	input wire logic [2:0] i_level,
	input wire logic i_trap_bit,
	output logic o_valid,
	output logic [6:0] o_vec,
	output logic o_is_trap
);
	logic [127:0] elig;
	logic [2:0] lvl [0:127];
	logic [2:0] best;

	for (genvar n = 0; n < vic_pkg::SLOTS; n++) begin : g_src
		assign lvl[n] = i_prio[4*n +: 3];
		// A trap in service lifts the core above every user level.
		assign elig[n] = i_pend[n] & i_en[n] & ~i_trap_bit & (lvl[n] > i_level);
	end

	always_comb begin
		o_valid = 1'b0;
		o_vec = 7'h00;
		o_is_trap = 1'b0;
		best = 3'h0;
		// Walking downward with >= lets the lower vector win a tie.
		for (int n = vic_pkg::SLOTS - 1; n >= 0; n--) begin
			if (elig[n] && lvl[n] >= best) begin
				o_valid = 1'b1;
				best = lvl[n];
				o_vec = 7'(n + vic_pkg::NUM_TRAP);
			end
		end
		// Traps are never masked and outrank every source.
		for (int t = vic_pkg::NUM_TRAP - 1; t >= 0; t--) begin
			if (i_trap[t]) begin
				o_valid = 1'b1;
				o_vec = 7'(t);
				o_is_trap = 1'b1;
			end
		end
	end
endmodule

//--- src/vic_vec_mem.sv
// Handler address store for the primary and alternate tables.
`timescale 1ns/10ps
module vic_vec_mem (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_wr_en,
	input wire logic [7:0] i_wr_idx,
	input wire logic i_wr_hi,
	input wire logic [15:0] i_wr_data,
	input wire logic [7:0] i_rd_idx,
	output logic [23:0] o_rd_data
);
	logic [23:0] mem [0:255];
	logic [23:0] rd_q;

	// The array has no reset; software loads every entry before enabling sources.
	always_ff @(posedge i_clk) begin
		if (i_wr_en && i_wr_hi) begin
			mem[i_wr_idx][23:16] <= i_wr_data[7:0];
		end else if (i_wr_en) begin
			mem[i_wr_idx][15:0] <= i_wr_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rd_q <= 24'h000000;
		end else begin
			rd_q <= mem[i_rd_idx];
		end
	end

	assign o_rd_data = rd_q;
endmodule

//--- src/vic_top.sv
// Vectored interrupt controller: flag banks, arbitration and vector dispatch.
`timescale 1ns/10ps
module vic_top (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [9:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	output logic [15:0] o_rdata,
	input wire logic [117:0] i_src_evt,
	input wire logic [3:0] i_trap_evt,
	input wire logic [2:0] i_core_priority_level,
	input wire logic i_trap_level_bit,
	output logic o_irq,
	output logic [6:0] o_vec_num,
	output logic o_is_trap,
	output logic [23:0] o_table_addr,
	output logic [23:0] o_handler_addr
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [127:0] pend_q;
	logic [127:0] pend_d;
	logic [127:0] en_q;
	logic [127:0] en_d;
	logic [511:0] prio_q;
	logic [511:0] prio_d;
	logic [15:0] trap_q;
	logic [15:0] trap_d;
	logic [15:0] ctrl2_q;
	logic [15:0] ctrl2_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic win_valid_q;
	logic win_valid_d;
	logic win_trap_q;
	logic win_trap_d;
	logic [6:0] win_vec_q;
	logic [6:0] win_vec_d;
	logic irq_q;
	logic irq_d;
	logic is_trap_q;
	logic is_trap_d;
	logic [6:0] vec_q;
	logic [6:0] vec_d;
	logic [23:0] taddr_q;
	logic [23:0] taddr_d;
	logic [127:0] src_evt_w;
	logic [7:0] trap_evt_w;
	logic hit_pend;
	logic hit_en;
	logic hit_prio;
	logic hit_vmem;
	logic [2:0] bank;
	logic [4:0] pword;
	logic alt_sel;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	assign hit_pend = (i_addr[9:3] == vic_pkg::PEND_BASE[9:3]);
	assign hit_en = (i_addr[9:3] == vic_pkg::EN_BASE[9:3]);
	assign hit_prio = (i_addr >= vic_pkg::PRIO_BASE) && (i_addr < vic_pkg::PRIO_END);
	assign hit_vmem = (i_addr[9] == vic_pkg::VMEM_BASE[9]);
	assign bank = i_addr[2:0];
	assign pword = 5'(i_addr - vic_pkg::PRIO_BASE);
	assign alt_sel = ctrl2_q[vic_pkg::ALT_BIT];

	// Only trap vectors 1 to 4 have a cause; the reserved ones stay silent.
	assign src_evt_w = {{vic_pkg::SRC_PAD{1'b0}}, i_src_evt};
	assign trap_evt_w = {3'h0, i_trap_evt, 1'b0};

	// ****************************************************************
	// Register bank
	// ****************************************************************
	always_comb begin
		pend_d = pend_q;
		en_d = en_q;
		prio_d = prio_q;
		trap_d = trap_q;
		ctrl2_d = ctrl2_q;
		if (i_we && hit_pend) begin
			pend_d[{bank, 4'h0} +: 16] = i_wdata;
		end
		if (i_we && hit_en) begin
			en_d[{bank, 4'h0} +: 16] = i_wdata;
		end
		if (i_we && hit_prio) begin
			prio_d[{pword, 4'h0} +: 16] = i_wdata & vic_pkg::PRIO_MASK;
		end
		if (i_we && i_addr == vic_pkg::TRAP_ADDR) begin
			trap_d = i_wdata & vic_pkg::TRAP_MASK;
		end
		if (i_we && i_addr == vic_pkg::CTRL2_ADDR) begin
			ctrl2_d = i_wdata & vic_pkg::CTRL2_MASK;
		end
		// Events are merged after the write so a clear in the same cycle loses.
		pend_d = (pend_d | src_evt_w) & vic_pkg::SRC_VALID;
		trap_d = trap_d | {8'h00, trap_evt_w};
	end

	always_comb begin
		rdata_d = 16'h0000;
		if (i_re && hit_pend) begin
			rdata_d = pend_q[{bank, 4'h0} +: 16];
		end else if (i_re && hit_en) begin
			rdata_d = en_q[{bank, 4'h0} +: 16];
		end else if (i_re && hit_prio) begin
			rdata_d = prio_q[{pword, 4'h0} +: 16];
		end else if (i_re && i_addr == vic_pkg::TRAP_ADDR) begin
			rdata_d = trap_q;
		end else if (i_re && i_addr == vic_pkg::CTRL2_ADDR) begin
			rdata_d = ctrl2_q;
		end else if (i_re && i_addr == vic_pkg::STAT_ADDR) begin
			rdata_d = {irq_q, is_trap_q, 7'h00, vec_q};
		end
	end

	// Reset clears state, except that the table address loads PRI_TABLE_BASE; no vector is fetched for it.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pend_q <= '0;
			en_q <= '0;
			prio_q <= '0;
			trap_q <= vic_pkg::REG_RST;
			ctrl2_q <= vic_pkg::REG_RST;
			rdata_q <= vic_pkg::REG_RST;
		end else begin
			pend_q <= pend_d;
			en_q <= en_d;
			prio_q <= prio_d;
			trap_q <= trap_d;
			ctrl2_q <= ctrl2_d;
			rdata_q <= rdata_d;
		end
	end

	// ****************************************************************
	// Arbitration and dispatch
	// ****************************************************************
	vic_arbiter u_arb (
		.i_pend(pend_q),
		.i_en(en_q),
		.i_prio(prio_q),
		.i_trap(trap_q[7:0]),
		.i_level(i_core_priority_level),
		.i_trap_bit(i_trap_level_bit),
		.o_valid(win_valid_d),
		.o_vec(win_vec_d),
		.o_is_trap(win_trap_d)
	);

	// Two fixed register stages keep the latency the same for every source.
	always_comb begin
		irq_d = win_valid_q;
		vec_d = win_vec_q;
		is_trap_d = win_trap_q;
		// Vector n lands at base plus 2n; sources start after the 8 traps.
		taddr_d = (alt_sel ? vic_pkg::ALT_TABLE_BASE : vic_pkg::PRI_TABLE_BASE)
			+ {16'h0000, win_vec_q, 1'b0};
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			win_valid_q <= 1'b0;
			win_trap_q <= 1'b0;
			win_vec_q <= 7'h00;
			irq_q <= 1'b0;
			is_trap_q <= 1'b0;
			vec_q <= 7'h00;
			taddr_q <= vic_pkg::PRI_TABLE_BASE;
		end else begin
			win_valid_q <= win_valid_d;
			win_trap_q <= win_trap_d;
			win_vec_q <= win_vec_d;
			irq_q <= irq_d;
			is_trap_q <= is_trap_d;
			vec_q <= vec_d;
			taddr_q <= taddr_d;
		end
	end

	// Entry index is {table select, vector}; vectors above 125 are never used.
	vic_vec_mem u_mem (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_wr_en(i_we && hit_vmem),
		.i_wr_idx(i_addr[8:1]),
		.i_wr_hi(i_addr[0]),
		.i_wr_data(i_wdata),
		.i_rd_idx({alt_sel, win_vec_q}),
		.o_rd_data(o_handler_addr)
	);

	assign o_rdata = rdata_q;
	assign o_irq = irq_q;
	assign o_vec_num = vec_q;
	assign o_is_trap = is_trap_q;
	assign o_table_addr = taddr_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	sequence s_cause;
		win_valid_d;
	endsequence

	sequence s_no_cause2;
		!win_valid_d ##1 !win_valid_d;
	endsequence

	sequence s_level7;
		(i_core_priority_level == vic_pkg::LEVEL_ALL_BLOCKED && trap_q == 16'h0000)[*3];
	endsequence

	property p_fixed_latency;
		s_cause |-> ##2 o_irq;
	endproperty
	a_fixed_latency: assert property (p_fixed_latency) else $error("request did not follow cause by two cycles");

	property p_needs_cause;
		s_no_cause2 |-> ##1 !o_irq;
	endproperty
	a_needs_cause: assert property (p_needs_cause) else $error("request raised with no eligible source");

	property p_primary_addr;
		o_irq && !$past(alt_sel) |-> o_table_addr == vic_pkg::PRI_TABLE_BASE + {16'h0000, o_vec_num, 1'b0};
	endproperty
	a_primary_addr: assert property (p_primary_addr) else $error("primary table address wrong");

	property p_alt_addr;
		o_irq && $past(alt_sel) |-> o_table_addr == vic_pkg::ALT_TABLE_BASE + {16'h0000, o_vec_num, 1'b0};
	endproperty
	a_alt_addr: assert property (p_alt_addr) else $error("alternate table address wrong");

	property p_alt_select;
		o_irq |-> o_table_addr[8] == $past(alt_sel);
	endproperty
	a_alt_select: assert property (p_alt_select) else $error("table select not honoured");

	property p_source_addr;
		o_irq && !o_is_trap && !$past(alt_sel) |->
			o_vec_num >= 7'h08 && o_table_addr == vic_pkg::SRC_TABLE_BASE + {16'h0000, o_vec_num - 7'h08, 1'b0};
	endproperty
	a_source_addr: assert property (p_source_addr) else $error("source vector address wrong");

	property p_trap_first;
		$past(trap_q != 16'h0000, 2) |-> o_irq && o_is_trap;
	endproperty
	a_trap_first: assert property (p_trap_first) else $error("pending trap not dispatched");

	property p_level7_blocks;
		s_level7 |-> !o_irq;
	endproperty
	a_level7_blocks: assert property (p_level7_blocks) else $error("user source taken at level 7");

	property p_flag_sticky;
		!(i_we && hit_pend) |=> (pend_q & $past(pend_q)) == $past(pend_q);
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without a write");

	property p_set_wins;
		src_evt_w != 128'h0 |=> (pend_q & $past(src_evt_w)) == $past(src_evt_w);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost against a clear");

	property p_not_reset_addr;
		o_irq |-> o_table_addr != vic_pkg::RESET_ADDR && !o_table_addr[0];
	endproperty
	a_not_reset_addr: assert property (p_not_reset_addr) else $error("vector fetch at reset address");

	// Reserved trap vectors have no cause, so only the four named traps may win as traps.
	property p_trap_vec;
		o_irq && o_is_trap |-> o_vec_num >= 7'(vic_pkg::TRAP_OSC_FAIL) && o_vec_num <= 7'(vic_pkg::TRAP_MATH_ERR);
	endproperty
	a_trap_vec: assert property (p_trap_vec) else $error("trap dispatched on a reserved vector");

	// A source vector must lie above the traps and inside the table.
	property p_user_vec;
		o_irq && !o_is_trap |-> o_vec_num >= 7'(vic_pkg::NUM_TRAP) && o_vec_num < 7'(vic_pkg::NUM_VEC);
	endproperty
	a_user_vec: assert property (p_user_vec) else $error("source dispatched outside its vector range");
endmodule

//--- dv/vic_core_model.sv
// Behavioural processor core that takes the single request and handler address.
`timescale 1ns/10ps
module vic_core_model (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_irq,
	input wire logic [23:0] i_handler_addr,
	input wire logic [2:0] i_level_set,
	input wire logic i_trap_set,
	output logic [2:0] o_core_priority_level,
	output logic o_trap_level_bit,
	output logic [23:0] o_last_handler
);
	// The level only moves on an edge, as an instruction writing it would.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_core_priority_level <= 3'h0;
			o_trap_level_bit <= 1'b0;
			o_last_handler <= 24'h000000;
		end else begin
			o_core_priority_level <= i_level_set;
			o_trap_level_bit <= i_trap_set;
			if (i_irq) begin
				o_last_handler <= i_handler_addr;
			end
		end
	end
endmodule

//--- dv/test_vectored_interrupt_controller.sv
// Self-checking bench for the vectored interrupt controller.
`timescale 1ns/10ps
module test_vectored_interrupt_controller;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic we = 1'b0;
	logic re = 1'b0;
	logic [9:0] addr = 10'h000;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic [117:0] sevt = '0;
	logic [3:0] tevt = 4'h0;
	logic [2:0] lvl_set = 3'h0;
	logic tset = 1'b0;
	logic [2:0] lvl;
	logic tbit;
	logic irq;
	logic is_trap;
	logic [6:0] vec;
	logic [23:0] taddr;
	logic [23:0] haddr;
	logic [23:0] seen;
	int miscompares = 0;
	int n_tests = 0;
	int n;

	vic_top i_dut (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_we(we), .i_re(re),
		.o_rdata(rdata), .i_src_evt(sevt), .i_trap_evt(tevt), .i_core_priority_level(lvl),
		.i_trap_level_bit(tbit), .o_irq(irq), .o_vec_num(vec), .o_is_trap(is_trap),
		.o_table_addr(taddr), .o_handler_addr(haddr));
	vic_core_model i_core (.i_clk(clk), .i_rstn(rstn), .i_irq(irq), .i_handler_addr(haddr),
		.i_level_set(lvl_set), .i_trap_set(tset), .o_core_priority_level(lvl),
		.o_trap_level_bit(tbit), .o_last_handler(seen));

	always #50 clk = ~clk;

	// ****************************************************************
	// Access tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask

	task automatic rd_chk(input string nm, input logic [9:0] a, input logic [15:0] e);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		@(negedge clk);
		chk(nm, {8'h00, e}, {8'h00, rdata});
	endtask

	// Handler values differ per entry so a wrong table index cannot pass.
	function automatic logic [23:0] hv(input logic [7:0] i);
		return {i ^ 8'h5a, 8'hc3, i};
	endfunction

	task automatic load(input logic [7:0] i);
		logic [23:0] h;
		h = hv(i);
		wr({1'b1, i, 1'b0}, h[15:0]);
		wr({1'b1, i, 1'b1}, {8'h00, h[23:16]});
	endtask

	task automatic pulse(input logic [117:0] m);
		@(posedge clk);
		sevt <= m;
		@(posedge clk);
		sevt <= '0;
	endtask

	task automatic trap(input logic [3:0] m);
		@(posedge clk);
		tevt <= m;
		@(posedge clk);
		tevt <= 4'h0;
	endtask

	task automatic exp_irq(input logic [6:0] v, input logic alt);
		int k;
		k = 0;
		while (irq !== 1'b1 && k < 6) begin
			@(negedge clk);
			k++;
		end
		@(negedge clk);
		chk("irq", 24'h1, {23'h0, irq});
		chk("vector", {17'h0, v}, {17'h0, vec});
		chk("is trap", {23'h0, v < 7'd8}, {23'h0, is_trap});
		chk("table", (alt ? 24'h000104 : 24'h000004) + {16'h0, v, 1'b0}, taddr);
		chk("handler", hv({alt, v}), seen);
	endtask

	task automatic exp_none();
		repeat (4) @(negedge clk);
		chk("no irq", 24'h0, {23'h0, irq});
	endtask

	task automatic lv(input logic [2:0] l, input logic t, input logic e);
		@(posedge clk);
		lvl_set <= l;
		tset <= t;
		repeat (5) @(negedge clk);
		chk("level gate", {23'h0, e}, {23'h0, irq});
	endtask

	// Must be entered at the edge that takes the clearing write.
	task automatic fall_lat(output int c);
		c = 0;
		@(negedge clk);
		while (irq === 1'b1 && c < 8) begin
			@(negedge clk);
			c++;
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		// Look after the first active edge, so the reset values are seen to hold.
		repeat (2) @(negedge clk);
		chk("reset table", 24'h000004, taddr);
		chk("reset irq", 24'h0, {23'h0, irq});
		rd_chk("trap flags", 10'h040, 16'h0000);
		rd_chk("unmapped", 10'h1f0, 16'h0000);
		for (int i = 1; i < 5; i++) begin
			load(8'(i));
			load(8'(i + 128));
		end
		load(8'd8);
		load(8'd9);
		load(8'd125);
		load(8'd136);
		wr(10'h020, 16'h0001);
		pulse(118'h1);
		exp_none();
		rd_chk("flag word", 10'h000, 16'h0001);
		wr(10'h010, 16'h0001);
		exp_irq(7'd8, 1'b0);
		rd_chk("status", 10'h042, 16'h8008);
		wr(10'h000, 16'h0000);
		fall_lat(n);
		chk("return lat", 24'(vic_pkg::DISPATCH_LATENCY), 24'(n));
		wr(10'h010, 16'h0003);
		wr(10'h020, 16'h0033);
		pulse(118'h3);
		exp_irq(7'd8, 1'b0);
		wr(10'h020, 16'h0051);
		repeat (4) @(negedge clk);
		exp_irq(7'd9, 1'b0);
		wr(10'h000, 16'h0000);
		exp_none();
		wr(10'h017, 16'h0020);
		wr(10'h03d, 16'h0070);
		pulse(118'h1 << 117);
		exp_irq(7'd125, 1'b0);
		lv(3'h7, 1'b0, 1'b0);
		lv(3'h6, 1'b0, 1'b1);
		wr(10'h03d, 16'h0030);
		lv(3'h3, 1'b0, 1'b0);
		lv(3'h2, 1'b0, 1'b1);
		lv(3'h0, 1'b1, 1'b0);
		for (int k = 1; k < 5; k++) begin
			trap(4'(1 << (k - 1)));
			exp_irq(7'(k), 1'b0);
			rd_chk("trap flags", 10'h040, 16'(1 << k));
			wr(10'h040, 16'h0000);
			fall_lat(n);
			chk("trap return lat", 24'(vic_pkg::DISPATCH_LATENCY), 24'(n));
		end
		lv(3'h0, 1'b0, 1'b1);
		trap(4'ha);
		repeat (4) @(negedge clk);
		exp_irq(7'd2, 1'b0);
		rd_chk("trap flags", 10'h040, 16'h0014);
		wr(10'h040, 16'h0000);
		repeat (4) @(negedge clk);
		exp_irq(7'd125, 1'b0);
		wr(10'h007, 16'h0000);
		exp_none();
		wr(10'h041, 16'h8000);
		rd_chk("control two", 10'h041, 16'h8000);
		pulse(118'h1);
		exp_irq(7'd8, 1'b1);
		trap(4'h1);
		repeat (4) @(negedge clk);
		exp_irq(7'd1, 1'b1);
		stop_test();
	end

	// Tests need well under 2000 cycles; this is about ten times that.
	initial begin
		#2ms;
		miscompares++;
		stop_test();
	end
endmodule
